/* File: core/backlight_protection_dimming_regs.sv */
// backlight controller register bank with dimming and switching timers
// assumes analog comparators and pin levels arrive asynchronously
//
// Operation
// - over-temperature flag read-only, live, resets 0
// - fault register low bits: brightness LSBs, reset 11
// - brightness upper byte register, reset 7F
// - over-voltage code bits 7:3, 2V steps
// - current-limit code bits 2:0, 50mV steps
// - over-voltage crossing raises protection event
// - switching codes 1..9 give 100..900 kHz
// - switching code zero stops gate drive
// - full-scale current code scales string current
// - internal dimming PWM 23 kHz, 10-bit duty
// - secondary device never drives boost gate
module backlight_protection_dimming_regs
  import bl_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  input wire logic over_temp_pin,
  input wire logic overvolt_comp_pin,
  input wire logic secondary_strap,
  output logic [3:0] string_enable,
  output logic [2:0] dim_mode,
  output logic [9:0] brightness_code,
  output logic [4:0] overvolt_threshold_code,
  output logic [2:0] current_limit_code,
  output logic [7:0] full_scale_current_code,
  output logic [2:0] short_threshold_code,
  output logic current_limit_recover,
  output logic ovp_event,
  output logic gate_drive,
  output logic dim_pwm
);
  typedef struct packed {
    logic [7:0] ctrl;      // string enables, dim source, dim mode
    logic [7:0] freq;      // recover mode, short threshold, switch_freq_code
    logic [7:0] iscale;    // full_scale_current_code
    logic [1:0] dim_lo;    // brightness_low_bits
    logic [7:0] dim_hi;    // brightness_high_bits
    logic [7:0] prot;      // overvolt_threshold_code and current_limit_code
    logic [7:0] ptr;       // register pointer, auto-increments
    logic [1:0] ot_s;      // over-temperature sync, [0] feeds [1] only
    logic otp;             // over-temperature flag
    logic [2:0] ov_s;      // comparator sync plus edge stage
    logic ovp_ev;          // one-cycle protection event
    logic [1:0] strap_s;   // strap sync
    logic strap_done;      // strap captured once after reset
    logic [1:0] strap_age; // clocks since release, lets the sync fill first
    logic secondary;       // cascaded secondary device
    logic [7:0] sw_cnt;    // switching period counter
    logic gate;            // gate drive level
    logic [9:0] pwm_cnt;   // internal dimming counter
    logic pwm;             // internal dimming level
  } bank_s;
  bank_s s_r, s_nxt;
  reg_link_if lnk ();
  logic [7:0] sw_period;
  logic [7:0] rdata;
  logic internal_pwm;
  logic [19:0] duty_lhs, duty_rhs;

  serial_port u_port (
    .mclk(mclk),
    .resetn(resetn),
    .scl(scl),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .lnk(lnk)
  );

  // read mux; unmapped offsets read zero
  always_comb begin
    case (s_r.ptr)
      OFS_CTRL: rdata = s_r.ctrl;
      OFS_FREQ: rdata = s_r.freq;
      OFS_ISCALE: rdata = s_r.iscale;
      // other fault flags live outside this bank and read zero
      OFS_FAULT: rdata = {5'h00, s_r.otp, s_r.dim_lo};
      OFS_BRIGHT: rdata = s_r.dim_hi;
      OFS_PROT: rdata = s_r.prot;
      OFS_VENDOR: rdata = VENDOR_CODE;
      default: rdata = 8'h00;
    endcase
  end
  assign lnk.rdata = rdata;

  // switching period in clocks; invalid codes give zero (off)
  always_comb begin
    if (s_r.freq[3:0] == 4'h0 || s_r.freq[3:0] > FS_MAX) begin
      sw_period = 8'h00;
    end else begin
      sw_period = SW_BASE_CYC / {4'h0, s_r.freq[3:0]};
    end
  end

  // internal dimming only when serial source and plain PWM mode
  assign internal_pwm = s_r.ctrl[IFACE_BIT] && s_r.ctrl[1:0] == 2'b00;
  // duty compare scaled so code 3FF gives full on, 0 gives off
  assign duty_lhs = 20'({s_r.dim_hi, s_r.dim_lo}) * 20'(PWM_CYC);
  assign duty_rhs = 20'(s_r.pwm_cnt) * 20'(DIM_FULL);

  // next state of the bank
  always_comb begin
    s_nxt = s_r;
    s_nxt.ot_s = {s_r.ot_s[0], over_temp_pin};
    s_nxt.otp = s_r.ot_s[1];
    s_nxt.ov_s = {s_r.ov_s[1:0], overvolt_comp_pin};
    s_nxt.ovp_ev = s_r.ov_s[1] & ~s_r.ov_s[2];
    s_nxt.strap_s = {s_r.strap_s[0], secondary_strap};
    // strap latched once, so a glitch later cannot hand over the gate
    // wait two clocks so the sync holds the pin, not its reset zero
    if (!s_r.strap_done) begin
      if (s_r.strap_age == 2'h2) begin
        s_nxt.strap_done = 1'b1;
        s_nxt.secondary = s_r.strap_s[1];
      end else begin
        s_nxt.strap_age = s_r.strap_age + 2'h1;
      end
    end
    // pointer load, writes and read advance
    if (lnk.ptr_stb) begin
      s_nxt.ptr = lnk.wdata;
    end else if (lnk.wr_stb) begin
      s_nxt.ptr = s_r.ptr + 8'h01;
      case (s_r.ptr)
        OFS_CTRL: s_nxt.ctrl = lnk.wdata;
        OFS_FREQ: s_nxt.freq = lnk.wdata;
        OFS_ISCALE: s_nxt.iscale = lnk.wdata;
        OFS_FAULT: s_nxt.dim_lo = lnk.wdata[1:0];
        OFS_BRIGHT: s_nxt.dim_hi = lnk.wdata;
        OFS_PROT: s_nxt.prot = lnk.wdata;
        default: ;
      endcase
    end else if (lnk.rd_adv) begin
      s_nxt.ptr = s_r.ptr + 8'h01;
    end
    // switching timer: high for first half of each period
    // gate stays low until the strap is known, so a secondary never pulses it
    if (sw_period == 8'h00 || s_r.secondary || !s_r.strap_done) begin
      s_nxt.sw_cnt = 8'h00;
      s_nxt.gate = 1'b0;
    end else begin
      if (s_r.sw_cnt >= sw_period - 8'h01) begin
        s_nxt.sw_cnt = 8'h00;
      end else begin
        s_nxt.sw_cnt = s_r.sw_cnt + 8'h01;
      end
      // comparator trip blanks the gate until it clears
      s_nxt.gate = (s_nxt.sw_cnt < (sw_period >> 1)) && !s_r.ov_s[1];
    end
    // internal dimming waveform at fixed rate
    if (!internal_pwm) begin
      s_nxt.pwm_cnt = 10'h000;
      s_nxt.pwm = 1'b0;
    end else begin
      s_nxt.pwm_cnt = (s_r.pwm_cnt >= PWM_CYC - 10'h001) ? 10'h000 : s_r.pwm_cnt + 10'h001;
      s_nxt.pwm = duty_lhs > duty_rhs;
    end
  end

  // single state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{ctrl: RST_CTRL, freq: RST_FREQ, iscale: RST_ISCALE, dim_lo: RST_DIM_LO,
               dim_hi: RST_BRIGHT, prot: RST_PROT, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  assign string_enable = s_r.ctrl[7:4];
  assign dim_mode = s_r.ctrl[2:0];
  assign brightness_code = {s_r.dim_hi, s_r.dim_lo};
  assign overvolt_threshold_code = s_r.prot[7:OVP_LSB];
  assign current_limit_code = s_r.prot[OVP_LSB-1:0];
  assign full_scale_current_code = s_r.iscale;
  assign short_threshold_code = s_r.freq[6:4];
  assign current_limit_recover = s_r.freq[7];
  assign ovp_event = s_r.ovp_ev;
  assign gate_drive = s_r.gate;
  assign dim_pwm = s_r.pwm;

  // flag shows in the fault read data one clock after the synchronised level
  otp_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_r.ot_s[1] && s_r.ptr == OFS_FAULT && !lnk.ptr_stb && !lnk.wr_stb && !lnk.rd_adv
    |=> rdata[OTP_BIT]) else $error("otp flag not set");
  // low brightness bits take the written value
  low_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    lnk.wr_stb && s_r.ptr == OFS_FAULT |=> brightness_code[1:0] == $past(lnk.wdata[1:0]))
    else $error("brightness low bits not written");
  // upper byte lands at code bits 9:2
  high_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    lnk.wr_stb && s_r.ptr == OFS_BRIGHT |=> brightness_code[9:2] == $past(lnk.wdata))
    else $error("brightness upper byte not written");
  // threshold fields follow a protection write
  ovp_field_a: assert property (@(posedge mclk) disable iff (!resetn)
    lnk.wr_stb && s_r.ptr == OFS_PROT |=> overvolt_threshold_code == $past(lnk.wdata[7:3]))
    else $error("overvoltage code wrong");
  ocp_field_a: assert property (@(posedge mclk) disable iff (!resetn)
    lnk.wr_stb && s_r.ptr == OFS_PROT |=> current_limit_code == $past(lnk.wdata[2:0]))
    else $error("current limit code wrong");
  // comparator rise gives one pulse one clock after synchroniser output
  ovp_pulse_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(s_r.ov_s[1]) |=> ovp_event ##1 !ovp_event) else $error("ovp event wrong");
  // zero code holds gate low
  fsw_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_r.freq[3:0] == 4'h0 |=> !gate_drive) else $error("gate switching while off");
  // secondary never switches
  cascade_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_r.secondary |=> !gate_drive) else $error("secondary drove gate");
  // no switching before the strap has been captured
  strap_wait_a: assert property (@(posedge mclk) disable iff (!resetn)
    !s_r.strap_done |=> !gate_drive) else $error("gate switched before strap known");
  // dimming output silent outside internal mode
  pwm_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
    !internal_pwm |=> !dim_pwm) else $error("internal pwm outside mode");
endmodule

/* File: core/bl_regs_pkg.sv */
// constants shared by the backlight register bank and its serial port
// assumes a single 20 MHz clock and an active-low asynchronous reset
package bl_regs_pkg;
  // serial bus slave address, 7 bits
  localparam logic [6:0] SLAVE_ADDR = 7'h31;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FREQ = 8'h01;
  localparam logic [7:0] OFS_ISCALE = 8'h02;
  localparam logic [7:0] OFS_FAULT = 8'h03;
  localparam logic [7:0] OFS_BRIGHT = 8'h04;
  localparam logic [7:0] OFS_PROT = 8'h05;
  localparam logic [7:0] OFS_VENDOR = 8'h06;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'hF0;
  localparam logic [7:0] RST_FREQ = 8'h44;
  localparam logic [7:0] RST_ISCALE = 8'h3B;
  localparam logic [1:0] RST_DIM_LO = 2'h3;
  localparam logic [7:0] RST_BRIGHT = 8'h7F;
  localparam logic [7:0] RST_PROT = 8'hE7;
  // vendor code: value is arbitrary
  localparam logic [7:0] VENDOR_CODE = 8'h5A;
  // field positions
  localparam int OTP_BIT = 2;
  localparam int IFACE_BIT = 2;
  localparam int OVP_LSB = 3;
  // highest valid switching code
  localparam logic [3:0] FS_MAX = 4'h9;
  // timing
  localparam longint CLK_HZ = 20_000_000;
  localparam longint SW_STEP_HZ = 100_000;
  localparam longint DIM_PWM_HZ = 23_000;
  localparam logic [7:0] SW_BASE_CYC = 8'(CLK_HZ / SW_STEP_HZ);
  localparam logic [9:0] PWM_CYC = 10'(CLK_HZ / DIM_PWM_HZ);
  localparam logic [9:0] DIM_FULL = 10'h3FF;
endpackage

/* File: core/reg_link_if.sv */
// strobes and data between the serial port and the register bank
// assumes both ends run on the same clock
interface reg_link_if;
  logic ptr_stb; // first data byte: register pointer
  logic wr_stb;  // later data byte: register write
  logic rd_adv;  // byte sent to host, advance pointer
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport link_side (output ptr_stb, wr_stb, rd_adv, wdata, input rdata);
  modport bank_side (input ptr_stb, wr_stb, rd_adv, wdata, output rdata);
endinterface

/* File: core/serial_port.sv */
// two-wire serial slave: address match, pointer byte, writes and reads
// assumes scl and sda come from pins, sda is open drain
module serial_port
  import bl_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  reg_link_if.link_side lnk
);
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_ADDR = 7'h02, S_ACKA = 7'h04, S_WR = 7'h08,
    S_ACKW = 7'h10, S_RD = 7'h20, S_ACKR = 7'h40
  } port_e;
  typedef struct packed {
    port_e st;
    logic [2:0] scl_s; // [0] is only read by [1]
    logic [2:0] sda_s;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] wdata; // byte handed to the bank with its strobe
    logic rw;
    logic first;
    logic oe;
    logic ptr_stb, wr_stb, rd_adv;
  } port_s;
  port_s s_r, s_nxt;
  logic scl_rise, scl_fall, start_c, stop_c;

  // edges on the synchronised copies only
  assign scl_rise = s_r.scl_s[1] & ~s_r.scl_s[2];
  assign scl_fall = ~s_r.scl_s[1] & s_r.scl_s[2];
  assign start_c = s_r.scl_s[1] & s_r.scl_s[2] & ~s_r.sda_s[1] & s_r.sda_s[2];
  assign stop_c = s_r.scl_s[1] & s_r.scl_s[2] & s_r.sda_s[1] & ~s_r.sda_s[2];

  // next state of the whole port
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_s = {s_r.scl_s[1:0], scl};
    s_nxt.sda_s = {s_r.sda_s[1:0], sda_in};
    s_nxt.ptr_stb = 1'b0;
    s_nxt.wr_stb = 1'b0;
    s_nxt.rd_adv = 1'b0;
    if (start_c) begin
      // repeated start allowed from any state
      s_nxt.st = S_ADDR;
      s_nxt.bitcnt = 4'h0;
      s_nxt.oe = 1'b0;
    end else if (stop_c) begin
      s_nxt.st = S_IDLE;
      s_nxt.oe = 1'b0;
    end else if (scl_rise) begin
      case (s_r.st)
        S_ADDR, S_WR: begin
          s_nxt.sh = {s_r.sh[6:0], s_r.sda_s[1]};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end
        S_RD: s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        // host nack ends the read burst
        S_ACKR: if (s_r.sda_s[1]) s_nxt.st = S_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (s_r.st)
        S_ADDR: if (s_r.bitcnt == 4'h8) begin
          if (s_r.sh[7:1] == SLAVE_ADDR) begin
            s_nxt.st = S_ACKA;
            s_nxt.rw = s_r.sh[0];
            s_nxt.oe = 1'b1;
          end else begin
            s_nxt.st = S_IDLE;
          end
        end
        S_ACKA: begin
          s_nxt.bitcnt = 4'h0;
          if (s_r.rw) begin
            s_nxt.st = S_RD;
            s_nxt.sh = lnk.rdata;
            s_nxt.oe = ~lnk.rdata[7];
          end else begin
            s_nxt.st = S_WR;
            s_nxt.first = 1'b1;
            s_nxt.oe = 1'b0;
          end
        end
        S_WR: if (s_r.bitcnt == 4'h8) begin
          s_nxt.st = S_ACKW;
          s_nxt.oe = 1'b1;
          s_nxt.first = 1'b0;
          s_nxt.ptr_stb = s_r.first;
          s_nxt.wr_stb = ~s_r.first;
          s_nxt.wdata = s_r.sh;
        end
        S_ACKW: begin
          s_nxt.st = S_WR;
          s_nxt.bitcnt = 4'h0;
          s_nxt.oe = 1'b0;
        end
        S_RD: begin
          if (s_r.bitcnt == 4'h8) begin
            s_nxt.st = S_ACKR;
            s_nxt.oe = 1'b0;
            s_nxt.rd_adv = 1'b1;
          end else begin
            s_nxt.sh = {s_r.sh[6:0], 1'b0};
            s_nxt.oe = ~s_r.sh[6];
          end
        end
        S_ACKR: begin
          s_nxt.st = S_RD;
          s_nxt.bitcnt = 4'h0;
          s_nxt.sh = lnk.rdata;
          s_nxt.oe = ~lnk.rdata[7];
        end
        default: s_nxt.st = S_IDLE;
      endcase
    end
  end

  // single state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{st: S_IDLE, scl_s: 3'h7, sda_s: 3'h7, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_oe = s_r.oe;
  assign lnk.ptr_stb = s_r.ptr_stb;
  assign lnk.wr_stb = s_r.wr_stb;
  assign lnk.rd_adv = s_r.rd_adv;
  assign lnk.wdata = s_r.wdata;
endmodule

/* File: tb/serial_host_model.sv */
// two-wire serial host model: start, stop, byte transfer, register access
// assumes the bench resolves sda as open drain with a pull-up
module serial_host_model
  import bl_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic sda, // resolved wire level
  output logic scl,
  output logic sda_pull // high while the host pulls sda low
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idles released with the clock line high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // half an scl period; 8 clocks keeps well clear of the 4-clock minimum
  task automatic half();
    repeat (8) @(posedge mclk);
  endtask

  // one bit: data moves one clock after scl falls so it never looks like a start
  task automatic bit_x(input logic b, output logic v);
    @(posedge mclk) sda_pull <= ~b;
    half();
    scl <= 1'b1;
    repeat (7) @(posedge mclk);
    @(negedge mclk) v = sda;
    @(posedge mclk) scl <= 1'b0;
  endtask

  // eight bits msb first, then the ninth bit; a 1 in last releases the line
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], v);
      q[i] = v;
    end
    bit_x(last, v);
    ack = ~v;
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start();
    @(posedge mclk) sda_pull <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b0;
  endtask

  // stop: sda rises while scl is high
  task automatic stop();
    @(posedge mclk) sda_pull <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b0;
    half();
  endtask

  // pointer then one or two data bytes; the pointer steps on its own
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1,
                           input logic two);
    logic [7:0] q;
    logic a;
    start();
    xfer({SLAVE_ADDR, 1'b0}, 1'b1, q, a);
    xfer(ptr, 1'b1, q, a);
    xfer(d0, 1'b1, q, a);
    if (two) xfer(d1, 1'b1, q, a);
    stop();
  endtask

  // set the pointer, repeated start, read one byte and end with a nack
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] q);
    logic [7:0] z;
    logic a;
    start();
    xfer({SLAVE_ADDR, 1'b0}, 1'b1, z, a);
    xfer(ptr, 1'b1, z, a);
    start();
    xfer({SLAVE_ADDR, 1'b1}, 1'b1, z, a);
    xfer(8'hFF, 1'b1, q, a);
    stop();
  endtask
endmodule

/* File: tb/test_backlight_protection_dimming_regs.sv */
// self-checking bench for the backlight register bank over its serial port
// assumes the host model in serial_host_model.sv and the shared package
module test_backlight_protection_dimming_regs
  import bl_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int sw_base = 20_000_000 / 100_000; // clocks per 100 kHz step
  localparam int dim_per = 20_000_000 / 23_000; // clocks per dimming period
  logic mclk, resetn, scl, sda_pull, sda_oe, over_temp_pin, overvolt_comp_pin, secondary_strap;
  logic [3:0] string_enable;
  logic [2:0] dim_mode, current_limit_code, short_threshold_code;
  logic [9:0] brightness_code;
  logic [4:0] overvolt_threshold_code;
  logic [7:0] full_scale_current_code;
  logic current_limit_recover, ovp_event, gate_drive, dim_pwm;
  wire logic sda = !(sda_oe || sda_pull); // open drain with pull-up
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int p, h, g, e;
  logic [9:0] dims [2] = '{10'h296, 10'h001}; // mid code and smallest nonzero

  backlight_protection_dimming_regs backlight_protection_dimming_regs_i (
    .mclk(mclk), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_oe(sda_oe),
    .over_temp_pin(over_temp_pin), .overvolt_comp_pin(overvolt_comp_pin),
    .secondary_strap(secondary_strap), .string_enable(string_enable), .dim_mode(dim_mode),
    .brightness_code(brightness_code), .overvolt_threshold_code(overvolt_threshold_code),
    .current_limit_code(current_limit_code), .full_scale_current_code(full_scale_current_code),
    .short_threshold_code(short_threshold_code), .current_limit_recover(current_limit_recover),
    .ovp_event(ovp_event), .gate_drive(gate_drive), .dim_pwm(dim_pwm));
  serial_host_model serial_host_model_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // hang guard: about three times the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90_000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // compare with case inequality so an unknown never matches
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    serial_host_model_i.write_reg(ptr, d, 8'h00, 1'b0);
  endtask

  task automatic rdchk(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] q;
    serial_host_model_i.read_reg(ptr, q);
    check($sformatf("reg %h", ptr), q, exp);
  endtask

  // strap must settle before release, so it is set before this is called
  task automatic do_reset();
    @(posedge mclk) resetn <= 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  // count gate highs and protection pulses over a window
  task automatic watch(input int n, output int gh, output int ev);
    gh = 0;
    ev = 0;
    repeat (n) begin
      @(negedge mclk);
      gh += (gate_drive === 1'b1) ? 1 : 0;
      ev += (ovp_event === 1'b1) ? 1 : 0;
    end
  endtask

  function automatic logic pick(input logic sel);
    return sel ? dim_pwm : gate_drive;
  endfunction

  // one full period from a rising edge; counts stop at 2000 if the line is stuck
  task automatic meas(input logic sel, output int per, output int hi);
    int k;
    logic lo;
    k = 0;
    per = 0;
    hi = 0;
    lo = 1'b0;
    while (pick(sel) !== 1'b0 && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    while (pick(sel) !== 1'b1 && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    do begin
      hi += (pick(sel) === 1'b1) ? 1 : 0;
      @(negedge mclk);
      per++;
      if (pick(sel) !== 1'b1) lo = 1'b1;
    end while (!(lo && pick(sel) === 1'b1) && per < 2000);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    over_temp_pin = 1'b0;
    overvolt_comp_pin = 1'b0;
    secondary_strap = 1'b0;
    do_reset();
    rdchk(OFS_FAULT, 8'h03);
    rdchk(OFS_BRIGHT, 8'h7F);
    rdchk(OFS_PROT, 8'hE7);
    rdchk(OFS_VENDOR, VENDOR_CODE);
    check("bright", brightness_code, 10'h1FF);
    check("ovp code", overvolt_threshold_code, 5'h1C);
    check("ocp code", current_limit_code, 3'h7);
    check("iscale", full_scale_current_code, 8'h3B);
    check("strings", string_enable, 4'hF);
    check("dim mode", dim_mode, 3'h0);
    check("short code", short_threshold_code, 3'h4);
    check("recover", current_limit_recover, 1'b0);
    rdchk(OFS_CTRL, 8'hF0);
    rdchk(OFS_FREQ, 8'h44);
    rdchk(OFS_ISCALE, 8'h3B);
    end_test("reset values");
    wr(OFS_FAULT, 8'hFE); // flag bits must ignore the write
    wr(OFS_BRIGHT, 8'h55);
    rdchk(OFS_FAULT, 8'h02);
    check("bright", brightness_code, 10'h156);
    @(posedge mclk) over_temp_pin <= 1'b1;
    rdchk(OFS_FAULT, 8'h06);
    @(posedge mclk) over_temp_pin <= 1'b0;
    rdchk(OFS_FAULT, 8'h02);
    end_test("fault and brightness");
    serial_host_model_i.write_reg(OFS_BRIGHT, 8'hA5, 8'h00, 1'b1); // pointer steps to 05
    check("ovp code", overvolt_threshold_code, 5'h00);
    check("ocp code", current_limit_code, 3'h0);
    rdchk(OFS_BRIGHT, 8'hA5);
    wr(OFS_PROT, 8'hFF); // all ones is the 80 V ceiling
    check("ovp code", overvolt_threshold_code, 5'h1F);
    check("ocp code", current_limit_code, 3'h7);
    wr(OFS_VENDOR, 8'h00); // read-only place
    rdchk(OFS_VENDOR, VENDOR_CODE);
    rdchk(8'h10, 8'h00); // unmapped offset
    wr(OFS_ISCALE, 8'hC4);
    check("iscale", full_scale_current_code, 8'hC4);
    end_test("thresholds and ids");
    @(posedge mclk) overvolt_comp_pin <= 1'b1;
    watch(8, g, e);
    check("ovp pulse", e, 1);
    watch(200, g, e);
    check("ovp gate", g, 0);
    check("ovp single", e, 0);
    @(posedge mclk) overvolt_comp_pin <= 1'b0;
    end_test("over voltage");
    // codes above nine are treated as off as well
    for (int c = 0; c <= 10; c++) begin
      wr(OFS_FREQ, 8'hC0 | 8'(c));
      if (c == 0 || c > 9) begin
        watch(500, g, e);
        check("gate off", g, 0);
      end else begin
        meas(1'b0, p, h);
        meas(1'b0, p, h);
        check("gate period", p, sw_base / c);
        check("gate high", h, sw_base / c / 2);
      end
    end
    check("recover", current_limit_recover, 1'b1);
    check("short code", short_threshold_code, 3'h4);
    end_test("switching");
    wr(OFS_CTRL, 8'hF4); // one controller sets dimming for all
    check("dim mode", dim_mode, 3'h4);
    check("strings", string_enable, 4'hF);
    foreach (dims[i]) begin
      wr(OFS_BRIGHT, dims[i][9:2]);
      wr(OFS_FAULT, {6'h00, dims[i][1:0]});
      meas(1'b1, p, h);
      meas(1'b1, p, h);
      check("dim period", p, dim_per);
      check("dim high", h, (int'(dims[i]) * dim_per + 1022) / 1023);
    end
    end_test("dimming");
    @(posedge mclk) secondary_strap <= 1'b1;
    do_reset();
    rdchk(OFS_BRIGHT, 8'h7F);
    watch(500, g, e);
    check("secondary gate", g, 0);
    end_test("secondary");
    final_report();
  end
endmodule
